// ### verilog/cgps_pkg.sv
package cgps_pkg;

    // =========================================================
    // Control field codes
    // =========================================================
    localparam logic [1:0] SEL_LOOP     = 2'h0;
    localparam logic [1:0] SEL_INTERNAL = 2'h1;
    localparam logic [1:0] SEL_EXTERNAL = 2'h2;

    // Clock source status codes
    localparam logic [1:0] SRC_FLL      = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_PLL      = 2'h3;

    // =========================================================
    // Divider and multiplier layout
    // =========================================================
    localparam int          REF_DIV_W       = 3;
    localparam int          VCO_W           = 4;
    localparam int          BUS_DIV_W       = 2;
    localparam int          FREQ_W          = 32;
    localparam int          SHIFT_W         = 4;
    // Extended divide adds a factor of 32 on the FLL path
    localparam logic [SHIFT_W-1:0] EXT_DIV_SHIFT = 4'h5;
    // Multiplier is four times the field value
    localparam int          VCO_STEP_SHIFT  = 2;
    // Bus clock is half the generator output
    localparam logic [SHIFT_W-1:0] BUS_CLK_SHIFT = 4'h1;
    // FLL output factor over its reference
    localparam int          FLL_FACTOR      = 512;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SWITCH_TIME_NS  = 50;
    localparam int LOCK_TIME_NS    = 1000;
    localparam int SWITCH_CYCLES   =
        (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CYCLES     =
        (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =========================================================
    // Operating modes
    // =========================================================
    typedef enum logic [2:0] {
        CGPS_LOWPWR_BYP = 3'b000,
        CGPS_LOOP_BYP   = 3'b001,
        CGPS_LOOP_ENG   = 3'b010,
        CGPS_FLL_BYP    = 3'b011,
        CGPS_FLL_ENG    = 3'b100,
        CGPS_INT        = 3'b101
    } cgps_mode_t;

endpackage : cgps_pkg

// ### verilog/cgps_settle.sv
`timescale 1ns/1ps

// Follows a target value only after it has held steady for CYCLES clocks
module cgps_settle
#(
    parameter int WIDTH  = 1,
    parameter int CYCLES = 5
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] target,
    output logic      [WIDTH-1:0] current,
    output logic                  settled
);

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);

    logic [WIDTH-1:0] held;
    logic [CNT_W-1:0] count;

    wire changed = (target != held);
    wire done    = (count == CNT_MAX);

    if (WIDTH < 1 || CYCLES < 1)
    begin : g_bad_params
        $error("cgps_settle: bad parameters");
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            held    <= '0;
            count   <= '0;
            current <= '0;
            settled <= 1'b0;
        end
        else
        begin
            held    <= target;
            count   <= changed ? '0 : (done ? count : count + 1'b1);
            current <= (done && !changed) ? held : current;
            settled <= done && !changed;
        end
    end

endmodule : cgps_settle

// ### verilog/cgps_sequencer.sv
`timescale 1ns/1ps

// Function
// - A set loop-source select chooses the PLL as loop source.
// - With reference divider 3 and extended divide select set, the division moves from 256 on the FLL to 8 on the PLL.
// - In bypassed low-power external mode the loop-source choice only prepares, the PLL drives nothing.
// - In a PLL mode the extended divide select has no effect on reference division.
// - VCO multiplier code 8 multiplies the PLL reference by 32.
// - The PLL is off in bypassed low-power mode; the multiplier acts once the PLL output feeds the generator, even if low-power select holds the PLL off.
// - Clearing low-power select in bypassed low-power mode with loop-source select set enters the PLL-bypassed external mode.
// - Loop-source status reads 1 once the PLL has settled as enabled (loop-source select set, low-power select clear).
// - Lock status is set when the PLL has acquired lock.
// - System clock select 0 picks the loop output as system clock, the PLL output when loop-source select is set.
// - Clock source status reads 3 while the PLL output feeds the generator output.
// - Output is reference over divider times multiplier over bus divider, bus clock is half of it.
// - System clock select 2 picks the external reference and status then reads 2.
// - A cleared loop-source select picks the FLL and the multiplier then has no effect.
module cgps_sequencer
    import cgps_pkg::*;
#(
    parameter int REF_KHZ = 8000
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [1:0]           system_clock_select,
    input  wire logic                 low_power_select,
    input  wire logic                 loop_source_select,
    input  wire logic                 extended_divide_select,
    input  wire logic [REF_DIV_W-1:0] reference_divider,
    input  wire logic [VCO_W-1:0]     vco_multiplier,
    input  wire logic [BUS_DIV_W-1:0] bus_divider,
    output logic                      loop_source_status,
    output logic                      lock_status,
    output logic [1:0]                clock_source_status,
    output cgps_mode_t                mode,
    output logic                      pll_enable,
    output logic [FREQ_W-1:0]         ref_div_factor,
    output logic [FREQ_W-1:0]         vco_factor,
    output logic [FREQ_W-1:0]         generator_output_khz,
    output logic [FREQ_W-1:0]         bus_clock_khz
);

    if (REF_KHZ < 1 || REF_KHZ > 65535)
    begin : g_bad_ref
        $error("cgps_sequencer: REF_KHZ out of range");
    end

    // =========================================================
    // Mode decode
    // =========================================================
    cgps_mode_t next_mode;
    wire ext_sel  = (system_clock_select == SEL_EXTERNAL);
    wire loop_sel = (system_clock_select == SEL_LOOP);

    always_comb
    begin
        next_mode = CGPS_INT;
        if (ext_sel)
        begin
            if (low_power_select)
                next_mode = CGPS_LOWPWR_BYP;
            else if (loop_source_select)
                next_mode = CGPS_LOOP_BYP;
            else
                next_mode = CGPS_FLL_BYP;
        end
        else if (loop_sel)
        begin
            next_mode = loop_source_select ? CGPS_LOOP_ENG : CGPS_FLL_ENG;
        end
    end

    // =========================================================
    // Loop and status targets
    // =========================================================
    // no PLL drive
    wire next_pll_en   = loop_source_select && !low_power_select;
    wire pll_mode      = loop_source_select;
    wire lock_req      = next_pll_en;

    logic [1:0] clk_target;
    always_comb
    begin
        unique case (system_clock_select)
            SEL_LOOP:
                clk_target = loop_source_select ? SRC_PLL : SRC_FLL;
            SEL_INTERNAL:
                clk_target = SRC_INTERNAL;
            default:
                clk_target = SRC_EXTERNAL;
        endcase
    end

    // =========================================================
    // Status settling
    // =========================================================
    logic       loop_now;
    logic       lock_settled;
    logic [1:0] clk_now;
    logic [REF_DIV_W+VCO_W:0] lock_key;
    assign lock_key = {lock_req, reference_divider, vco_multiplier};

    cgps_settle #(.WIDTH(1), .CYCLES(SWITCH_CYCLES)) u_loop
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .target  (next_pll_en),
        .current (loop_now),
        .settled ()
    );

    cgps_settle #(.WIDTH(REF_DIV_W+VCO_W+1), .CYCLES(LOCK_CYCLES)) u_lock
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .target  (lock_key),
        .current (),
        .settled (lock_settled)
    );

    cgps_settle #(.WIDTH(2), .CYCLES(SWITCH_CYCLES)) u_clk
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .target  (clk_target),
        .current (clk_now),
        .settled ()
    );

    // =========================================================
    // Frequency path
    // =========================================================
    // divider by loop
    wire [SHIFT_W-1:0] base_shift = SHIFT_W'(reference_divider);
    wire [SHIFT_W-1:0] ref_shift  =
        (!pll_mode && extended_divide_select)
            ? base_shift + EXT_DIV_SHIFT : base_shift;
    wire [FREQ_W-1:0] next_ref_div = FREQ_W'(1) << ref_shift;

    wire [FREQ_W-1:0] next_vco =
        FREQ_W'(vco_multiplier) << VCO_STEP_SHIFT;

    wire [FREQ_W-1:0] ref_khz_w  = FREQ_W'(REF_KHZ);
    wire [FREQ_W-1:0] loop_ref   = ref_khz_w >> ref_shift;
    wire [FREQ_W-1:0] pll_out    = loop_ref * next_vco;
    wire [FREQ_W-1:0] fll_out    = loop_ref * FREQ_W'(FLL_FACTOR);

    // Output follows the source that really feeds it
    logic [FREQ_W-1:0] src_khz;
    always_comb
    begin
        unique case (clk_now)
            SRC_PLL:      src_khz = pll_out;
            SRC_FLL:      src_khz = fll_out;
            SRC_EXTERNAL: src_khz = ref_khz_w;
            default:        src_khz = '0;
        endcase
    end

    wire [FREQ_W-1:0] next_gen_out = src_khz >> bus_divider;
    wire [FREQ_W-1:0] next_bus_clk = next_gen_out >> BUS_CLK_SHIFT;

    // =========================================================
    // Output registers
    // =========================================================
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mode                 <= CGPS_INT;
            pll_enable           <= 1'b0;
            loop_source_status   <= 1'b0;
            lock_status          <= 1'b0;
            clock_source_status  <= SRC_FLL;
            ref_div_factor       <= '0;
            vco_factor           <= '0;
            generator_output_khz <= '0;
            bus_clock_khz        <= '0;
        end
        else
        begin
            mode                 <= next_mode;
            pll_enable           <= next_pll_en;
            loop_source_status   <= loop_now;
            // Stale settle from a loop-off key must not show
            lock_status          <= lock_settled && lock_req && pll_enable;
            clock_source_status  <= clk_now;
            ref_div_factor       <= next_ref_div;
            vco_factor           <= next_vco;
            generator_output_khz <= next_gen_out;
            bus_clock_khz        <= next_bus_clk;
        end
    end

endmodule : cgps_sequencer

// ### test/cgps_sequencer_assertions.sv
`timescale 1ns/1ps

module cgps_checker
    import cgps_pkg::*;
(
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic [1:0]           system_clock_select,
    input wire logic                 low_power_select,
    input wire logic                 loop_source_select,
    input wire logic                 extended_divide_select,
    input wire logic [REF_DIV_W-1:0] reference_divider,
    input wire logic [VCO_W-1:0]     vco_multiplier,
    input wire logic                 loop_source_status,
    input wire logic                 lock_status,
    input wire logic [1:0]           clock_source_status,
    input wire cgps_mode_t           mode,
    input wire logic                 pll_enable,
    input wire logic [FREQ_W-1:0]    ref_div_factor,
    input wire logic [FREQ_W-1:0]    vco_factor
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // =========================================================
    // Settling sequences
    // =========================================================
    sequence s_pll_held; pll_enable[*8]; endsequence
    sequence s_eng_held; (mode == CGPS_LOOP_ENG)[*8]; endsequence
    sequence s_fll_held; (mode == CGPS_FLL_ENG)[*8]; endsequence
    sequence s_ext_held; (system_clock_select == SEL_EXTERNAL)[*8];
    endsequence
    sequence s_leave_lowpwr;
        $fell(low_power_select) && mode == CGPS_LOWPWR_BYP
        && loop_source_select && system_clock_select == SEL_EXTERNAL;
    endsequence

    a_pll_off_lowpwr: assert property (mode == CGPS_LOWPWR_BYP
        |-> !pll_enable)
        else $error("loop running in bypassed low power mode");
    a_enter_loop_byp: assert property (s_leave_lowpwr
        |=> mode == CGPS_LOOP_BYP)
        else $error("bypassed loop mode not entered");
    a_ref_div_pll: assert property (loop_source_select
        && reference_divider == 3'h3 |=> ref_div_factor == 32'h0000_0008)
        else $error("loop reference division wrong");
    a_ref_div_fll: assert property (!loop_source_select
        && extended_divide_select && reference_divider == 3'h3
        |=> ref_div_factor == 32'h0000_0100)
        else $error("frequency loop division wrong");
    a_vco_factor: assert property (vco_multiplier == 4'h8
        |=> vco_factor == 32'h0000_0020)
        else $error("multiplier factor wrong");
    a_src_status_set: assert property (s_pll_held
        |-> ##2 loop_source_status)
        else $error("loop source status not set");
    a_src_status_late: assert property ($rose(loop_source_status)
        |-> $past(pll_enable, 4))
        else $error("loop source status set too early");
    a_lock_needs_pll: assert property ($rose(lock_status)
        |-> pll_enable && loop_source_status)
        else $error("lock without running loop");
    a_lock_drops: assert property ($fell(pll_enable)
        |-> ##[0:2] !lock_status)
        else $error("lock kept after loop stop");
    a_clk_src_pll: assert property (s_eng_held
        |-> ##4 clock_source_status == SRC_PLL)
        else $error("loop output status missing");
    a_clk_src_ext: assert property (s_ext_held
        |-> ##4 clock_source_status == SRC_EXTERNAL)
        else $error("external status missing");
    a_clk_src_fll: assert property (s_fll_held
        |-> ##4 clock_source_status == SRC_FLL)
        else $error("frequency loop status missing");
endmodule : cgps_checker

bind cgps_sequencer cgps_checker u_chk (.ref_clk, .rst, .system_clock_select,
    .low_power_select, .loop_source_select, .extended_divide_select,
    .reference_divider, .vco_multiplier, .loop_source_status, .lock_status,
    .clock_source_status, .mode, .pll_enable, .ref_div_factor, .vco_factor);

// ### test/testbench.sv
`timescale 1ns/1ps

module testbench;
    import cgps_pkg::*;

    localparam int REF_KHZ = 8000;
    localparam int FLL_KHZ = REF_KHZ / 256 * FLL_FACTOR;

    logic                 ref_clk;
    logic                 rst;
    logic [1:0]           system_clock_select;
    logic                 low_power_select;
    logic                 loop_source_select;
    logic                 extended_divide_select;
    logic [REF_DIV_W-1:0] reference_divider;
    logic [VCO_W-1:0]     vco_multiplier;
    logic [BUS_DIV_W-1:0] bus_divider;
    logic                 loop_source_status;
    logic                 lock_status;
    logic [1:0]           clock_source_status;
    cgps_mode_t           mode;
    logic                 pll_enable;
    logic [FREQ_W-1:0]    ref_div_factor;
    logic [FREQ_W-1:0]    vco_factor;
    logic [FREQ_W-1:0]    generator_output_khz;
    logic [FREQ_W-1:0]    bus_clock_khz;
    int                   mismatches = 0;
    int                   n_tests = 0;

    cgps_sequencer #(.REF_KHZ(REF_KHZ)) DUT (.ref_clk, .rst,
        .system_clock_select, .low_power_select, .loop_source_select,
        .extended_divide_select, .reference_divider, .vco_multiplier,
        .bus_divider, .loop_source_status, .lock_status, .clock_source_status,
        .mode, .pll_enable, .ref_div_factor, .vco_factor,
        .generator_output_khz, .bus_clock_khz);

    // =========================================================
    // Helpers
    // =========================================================
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset();
        chk({loop_source_status, lock_status, clock_source_status}, 0, "rst");
        chk(mode, CGPS_INT, "reset mode");
    endtask : t_reset

    task automatic t_prepare();
        low_power_select = 1'b1;
        extended_divide_select = 1'b1;
        reference_divider = 3'h3;
        vco_multiplier = 4'h8;
        cyc(2);
        chk(ref_div_factor, 32'h0000_0100, "fll division");
        chk(mode, CGPS_LOWPWR_BYP, "bypassed low power mode");
        loop_source_select = 1'b1;
        cyc(1);
        chk(ref_div_factor, 32'h0000_0008, "pll division");
        chk(vco_factor, 32'h0000_0020, "multiplier");
        cyc(20);
        chk(pll_enable, 1'b0, "loop enabled early");
        chk(loop_source_status, 1'b0, "loop used early");
        chk(clock_source_status, SRC_EXTERNAL, "external status");
    endtask : t_prepare

    task automatic t_pbe();
        low_power_select = 1'b0;
        cyc(1);
        chk(mode, CGPS_LOOP_BYP, "bypassed loop mode");
        cyc(2);
        chk(loop_source_status, 1'b0, "status early");
        for (int i = 0; i < 30 && loop_source_status !== 1'b1; i++) cyc(1);
        chk(loop_source_status, 1'b1, "loop source status");
        chk(lock_status, 1'b0, "lock early");
        for (int i = 0; i < 200 && lock_status !== 1'b1; i++) cyc(1);
        chk(lock_status, 1'b1, "lock status");
    endtask : t_pbe

    task automatic t_pee();
        system_clock_select = SEL_LOOP;
        cyc(2);
        chk(clock_source_status, SRC_EXTERNAL, "switch early");
        for (int i = 0; i < 30 && clock_source_status !== SRC_PLL; i++)
            cyc(1);
        chk(clock_source_status, SRC_PLL, "loop output status");
        cyc(3);
        chk(generator_output_khz, 32'(REF_KHZ / 8 * 32), "output");
        chk(bus_clock_khz, 32'(REF_KHZ / 16 * 32), "bus clock");
        bus_divider = 2'h1;
        cyc(4);
        chk(generator_output_khz, 32'(REF_KHZ / 16 * 32), "bus div");
    endtask : t_pee

    task automatic t_back();
        system_clock_select = SEL_EXTERNAL;
        for (int i = 0; i < 30 && clock_source_status !== SRC_EXTERNAL; i++)
            cyc(1);
        chk(clock_source_status, SRC_EXTERNAL, "back to external");
        loop_source_select = 1'b0;
        cyc(1);
        chk(ref_div_factor, 32'h0000_0100, "fll again");
        for (int i = 0; i < 30 && loop_source_status !== 1'b0; i++) cyc(1);
        chk(loop_source_status, 1'b0, "fll source");
        chk(lock_status, 1'b0, "lock cleared");
    endtask : t_back

    task automatic t_fll();
        system_clock_select = SEL_LOOP;
        cyc(1);
        chk(mode, CGPS_FLL_ENG, "fll engaged mode");
        for (int i = 0; i < 30 && clock_source_status !== SRC_FLL; i++)
            cyc(1);
        chk(clock_source_status, SRC_FLL, "fll output status");
        // Bus divider still one from the engaged scenario
        chk(generator_output_khz, 32'(FLL_KHZ / 2), "fll out");
        system_clock_select = SEL_INTERNAL;
        cyc(1);
        chk(mode, CGPS_INT, "internal mode");
        for (int i = 0; i < 30 && clock_source_status !== SRC_INTERNAL; i++)
            cyc(1);
        chk(clock_source_status, SRC_INTERNAL, "internal status");
        chk(generator_output_khz, 0, "internal output");
        // Lock key settles with loop off, then loop enabled
        cyc(110);
        loop_source_select = 1'b1;
        cyc(1);
        chk(lock_status, 1'b0, "stale lock");
        cyc(1);
        chk(lock_status, 1'b0, "lock before settle");
    endtask : t_fll

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        rst = 1'b1;
        system_clock_select = SEL_EXTERNAL;
        low_power_select = 1'b0;
        loop_source_select = 1'b0;
        extended_divide_select = 1'b0;
        reference_divider = 3'h0;
        vco_multiplier = 4'h0;
        bus_divider = 2'h0;
        cyc(10);
        t_reset();
        rst = 1'b0;
        cyc(1);
        t_prepare();
        t_pbe();
        t_pee();
        t_back();
        t_fll();
        give_verdict();
    end
endmodule : testbench
